// File: hw/legacy_mode_ctrl.sv
// Legacy parallel-video mode register file and long-packet filter.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns
module legacy_mode_ctrl
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Device pins
  input  wire logic       powerdownPin_n,
  input  wire logic [2:0] modeStrap,
  // Register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdata,
  // Back channel format load
  input  wire logic       rxLock,
  input  wire logic       bcLoad,
  input  wire logic       bcRaw10,
  input  wire logic       bcRaw12,
  // Camera packet input
  input  wire logic       pktValid,
  input  wire logic [5:0] pktType,
  input  wire logic       frameValidIn,
  input  wire logic       lineValidIn,
  // Forward path and mode outputs
  output logic            pktPass,
  output logic            frameValidOut,
  output logic            lineValidOut,
  output logic      [2:0] modeActive,
  output logic            legacyMode
);
  import legacy_mode_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [2:0] mode_q;
  logic       modeDone_q;
  logic       strapOverride_q;
  logic       pdSeen_q;
  logic       raw10Sel_q;
  logic       raw12Sel_q;
  logic       autoBlock_q;
  logic [4:0] filterCfg_q;
  logic [5:0] matchVal_q;
  logic [7:0] regRdata_q;
  logic       pktPass_q;
  logic       frameValid_q;
  logic       lineValid_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire        wrMode    = regWrite && regAddr == OFF_MODE;
  wire        wrFormat  = regWrite && regAddr == OFF_FORMAT;
  wire        wrFilter  = regWrite && regAddr == OFF_FILTER;
  wire        wrMatch   = regWrite && regAddr == OFF_MATCH
                          && !filterCfg_q[FLT_MATCH_BIT];
  wire        pdRise    = powerdownPin_n && !pdSeen_q;
  wire        autoLoad  = rxLock && bcLoad && !autoBlock_q;
  wire        isLong    = pktType[5] || pktType[4];
  wire        matchLong = matchVal_q[5] || matchVal_q[4];
  wire        isYuv10   = pktType == DT_YUV420_10 || pktType == DT_YUV420_10CS
                          || pktType == DT_YUV422_10;
  wire        fmtHit    = (raw10Sel_q && pktType == DT_RAW10)
                          || (raw12Sel_q && pktType == DT_RAW12);
  wire        anyHit    = filterCfg_q[FLT_ANY_BIT] && isLong;
  wire        matchHit  = filterCfg_q[FLT_MATCH_BIT] && matchLong
                          && pktType == matchVal_q;
  wire        yuvHit    = filterCfg_q[FLT_YUV_BIT] && raw10Sel_q && isYuv10;
  wire        passNow   = pktValid && (fmtHit || anyHit || matchHit || yuvHit);
  wire [7:0]  modeRd    = {3'h0, strapOverride_q, modeDone_q, mode_q};
  wire [7:0]  fmtRd     = {5'h00, raw10Sel_q, raw12Sel_q, autoBlock_q};
  wire [7:0]  rdMux     = regAddr == OFF_MODE   ? modeRd :
                          regAddr == OFF_FORMAT ? fmtRd :
                          regAddr == OFF_FILTER ? {3'h0, filterCfg_q} :
                          regAddr == OFF_MATCH  ? {2'h0, matchVal_q} :
                          8'h00;

  assign legacyMode    = mode_q == MODE_LEGACY;
  assign modeActive    = mode_q;
  assign regRdata      = regRdata_q;
  assign pktPass       = pktPass_q;
  assign frameValidOut = frameValid_q;
  assign lineValidOut  = lineValid_q;

  // ----------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------
  // The strap is caught on the clocked edge after release, never by reset itself.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_q          <= MODE_CSI_SYNC;
      modeDone_q      <= 1'b0;
      strapOverride_q <= 1'b0;
      pdSeen_q        <= 1'b0;
    end
    else
    begin
      pdSeen_q <= powerdownPin_n;
      if (!powerdownPin_n)
        modeDone_q <= 1'b0;
      else if (pdRise)
      begin
        mode_q     <= modeStrap;
        modeDone_q <= 1'b1;
      end
      else if (wrMode && strapOverride_q)
        mode_q <= regWdata[2:0];
      if (wrMode)
        strapOverride_q <= regWdata[STRAP_OVERRIDE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Format and filter registers
  // ----------------------------------------------------------------
  // The back channel load wins over a same-cycle software write unless blocked.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      raw10Sel_q  <= 1'b0;
      raw12Sel_q  <= 1'b0;
      autoBlock_q <= 1'b0;
      filterCfg_q <= 5'h00;
      matchVal_q  <= 6'h00;
    end
    else
    begin
      if (wrFormat)
        autoBlock_q <= regWdata[FMT_BLOCK_BIT];
      if (autoLoad)
      begin
        raw10Sel_q <= bcRaw10;
        raw12Sel_q <= bcRaw12;
      end
      else if (wrFormat)
      begin
        raw10Sel_q <= regWdata[FMT_RAW10_BIT];
        raw12Sel_q <= regWdata[FMT_RAW12_BIT];
      end
      if (wrFilter)
        filterCfg_q <= regWdata[4:0];
      if (wrMatch)
        matchVal_q <= regWdata[5:0];
    end
  end

  // ----------------------------------------------------------------
  // Read data and forward path
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      regRdata_q   <= RST_REG;
      pktPass_q    <= 1'b0;
      frameValid_q <= 1'b0;
      lineValid_q  <= 1'b0;
    end
    else
    begin
      regRdata_q   <= regRead ? rdMux : RST_REG;
      pktPass_q    <= passNow;
      frameValid_q <= frameValidIn ^ filterCfg_q[FLT_FVINV_BIT];
      lineValid_q  <= lineValidIn ^ filterCfg_q[FLT_LVINV_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_modeLocked;
    @(posedge clk) disable iff (!reset_n)
    (wrMode && !strapOverride_q && !pdRise) |=> mode_q == $past(mode_q);
  endproperty
  a_modeLocked: assert property (p_modeLocked) else $error("Mode changed while locked.");

  property p_modeWrite;
    @(posedge clk) disable iff (!reset_n)
    (wrMode && strapOverride_q && !pdRise) |=> mode_q == $past(regWdata[2:0]);
  endproperty
  a_modeWrite: assert property (p_modeWrite) else $error("Mode write lost.");

  property p_strapCapture;
    @(posedge clk) disable iff (!reset_n)
    (powerdownPin_n && !pdSeen_q) |=> (mode_q == $past(modeStrap)) && modeDone_q;
  endproperty
  a_strapCapture: assert property (p_strapCapture) else $error("Strap not captured.");

  property p_matchBlocked;
    @(posedge clk) disable iff (!reset_n)
    (regWrite && regAddr == OFF_MATCH && filterCfg_q[FLT_MATCH_BIT])
      |=> $stable(matchVal_q);
  endproperty
  a_matchBlocked: assert property (p_matchBlocked) else $error("Match value written.");

  property p_autoBlocked;
    @(posedge clk) disable iff (!reset_n)
    (autoBlock_q && !wrFormat) |=> $stable(raw10Sel_q) && $stable(raw12Sel_q);
  endproperty
  a_autoBlocked: assert property (p_autoBlocked) else $error("Blocked format changed.");

  property p_anyPass;
    @(posedge clk) disable iff (!reset_n)
    (pktValid && filterCfg_q[FLT_ANY_BIT] && pktType[5]) |=> pktPass;
  endproperty
  a_anyPass: assert property (p_anyPass) else $error("Long packet dropped.");

  property p_drop;
    @(posedge clk) disable iff (!reset_n)
    !pktValid |=> !pktPass;
  endproperty
  a_drop: assert property (p_drop) else $error("Pass without packet.");

  property p_fvInvert;
    @(posedge clk) disable iff (!reset_n)
    ##1 frameValidOut == ($past(frameValidIn) ^ $past(filterCfg_q[FLT_FVINV_BIT]));
  endproperty
  a_fvInvert: assert property (p_fvInvert) else $error("Frame valid polarity wrong.");

  property p_noLock;
    @(posedge clk) disable iff (!reset_n)
    (regRead && regAddr == OFF_STATUS) |=> regRdata == 8'h00;
  endproperty
  a_noLock: assert property (p_noLock) else $error("Status shows lock.");

  // ----------------------------------------------------------------
  // Register and filter checks
  // ----------------------------------------------------------------
  property p_matchWrite;
    @(posedge clk) disable iff (!reset_n)
    wrMatch |=> matchVal_q == $past(regWdata[5:0]);
  endproperty
  a_matchWrite: assert property (p_matchWrite) else $error("Match write lost.");

  property p_filterWrite;
    @(posedge clk) disable iff (!reset_n)
    wrFilter |=> filterCfg_q == $past(regWdata[4:0]);
  endproperty
  a_filterWrite: assert property (p_filterWrite) else $error("Filter write lost.");

  property p_ovWrite;
    @(posedge clk) disable iff (!reset_n)
    wrMode |=> strapOverride_q == $past(regWdata[STRAP_OVERRIDE_BIT]);
  endproperty
  a_ovWrite: assert property (p_ovWrite) else $error("Override write lost.");

  property p_blockWrite;
    @(posedge clk) disable iff (!reset_n)
    wrFormat |=> autoBlock_q == $past(regWdata[FMT_BLOCK_BIT]);
  endproperty
  a_blockWrite: assert property (p_blockWrite) else $error("Block write lost.");

  property p_autoLoad;
    @(posedge clk) disable iff (!reset_n)
    autoLoad |=> raw10Sel_q == $past(bcRaw10) && raw12Sel_q == $past(bcRaw12);
  endproperty
  a_autoLoad: assert property (p_autoLoad) else $error("Format load lost.");

  property p_fmtWrite;
    @(posedge clk) disable iff (!reset_n)
    (wrFormat && !autoLoad) |=> raw10Sel_q == $past(regWdata[FMT_RAW10_BIT])
      && raw12Sel_q == $past(regWdata[FMT_RAW12_BIT]);
  endproperty
  a_fmtWrite: assert property (p_fmtWrite) else $error("Format write lost.");

  property p_fmtHold;
    @(posedge clk) disable iff (!reset_n)
    (!wrFormat && !autoLoad) |=> $stable(raw10Sel_q) && $stable(raw12Sel_q);
  endproperty
  a_fmtHold: assert property (p_fmtHold) else $error("Format changed alone.");

  property p_lvInvert;
    @(posedge clk) disable iff (!reset_n)
    1'b1 |=> lineValidOut == ($past(lineValidIn) ^ $past(filterCfg_q[FLT_LVINV_BIT]));
  endproperty
  a_lvInvert: assert property (p_lvInvert) else $error("Line valid polarity wrong.");

  property p_rawTenPass;
    @(posedge clk) disable iff (!reset_n)
    (pktValid && raw10Sel_q && pktType == DT_RAW10) |=> pktPass;
  endproperty
  a_rawTenPass: assert property (p_rawTenPass) else $error("Ten-bit packet dropped.");

  property p_rawTwelvePass;
    @(posedge clk) disable iff (!reset_n)
    (pktValid && raw12Sel_q && pktType == DT_RAW12) |=> pktPass;
  endproperty
  a_rawTwelvePass: assert property (p_rawTwelvePass) else $error("Twelve-bit dropped.");

  property p_matchPass;
    @(posedge clk) disable iff (!reset_n)
    (pktValid && filterCfg_q[FLT_MATCH_BIT] && matchLong && pktType == matchVal_q)
      |=> pktPass;
  endproperty
  a_matchPass: assert property (p_matchPass) else $error("Matched packet dropped.");

  property p_yuvPass;
    @(posedge clk) disable iff (!reset_n)
    (pktValid && filterCfg_q[FLT_YUV_BIT] && raw10Sel_q && isYuv10) |=> pktPass;
  endproperty
  a_yuvPass: assert property (p_yuvPass) else $error("YUV10 packet dropped.");

  property p_shortDrop;
    @(posedge clk) disable iff (!reset_n)
    (!pktType[5] && !pktType[4]) |=> !pktPass;
  endproperty
  a_shortDrop: assert property (p_shortDrop) else $error("Short packet passed.");

  property p_noFilterDrop;
    @(posedge clk) disable iff (!reset_n)
    (!fmtHit && filterCfg_q[4:2] == 3'h0) |=> !pktPass;
  endproperty
  a_noFilterDrop: assert property (p_noFilterDrop) else $error("Unselected passed.");

  property p_doneClear;
    @(posedge clk) disable iff (!reset_n)
    !powerdownPin_n |=> !modeDone_q;
  endproperty
  a_doneClear: assert property (p_doneClear) else $error("Done kept in power-down.");

  property p_doneHold;
    @(posedge clk) disable iff (!reset_n)
    (powerdownPin_n && pdSeen_q) |=> $stable(modeDone_q);
  endproperty
  a_doneHold: assert property (p_doneHold) else $error("Done flag moved.");

  property p_legacyDecode;
    @(posedge clk) disable iff (!reset_n)
    legacyMode == (modeActive == MODE_LEGACY);
  endproperty
  a_legacyDecode: assert property (p_legacyDecode) else $error("Legacy decode wrong.");

  property p_modeRead;
    @(posedge clk) disable iff (!reset_n)
    (regRead && regAddr == OFF_MODE)
      |=> regRdata == {3'h0, $past(strapOverride_q), $past(modeDone_q), $past(mode_q)};
  endproperty
  a_modeRead: assert property (p_modeRead) else $error("Mode read wrong.");

  property p_readIdle;
    @(posedge clk) disable iff (!reset_n)
    !regRead |=> regRdata == 8'h00;
  endproperty
  a_readIdle: assert property (p_readIdle) else $error("Read data without read.");

  property p_fmtRead;
    @(posedge clk) disable iff (!reset_n)
    (regRead && regAddr == OFF_FORMAT)
      |=> regRdata == {5'h00, $past(raw10Sel_q), $past(raw12Sel_q), $past(autoBlock_q)};
  endproperty
  a_fmtRead: assert property (p_fmtRead) else $error("Format read wrong.");

  property p_filterRead;
    @(posedge clk) disable iff (!reset_n)
    (regRead && regAddr == OFF_FILTER) |=> regRdata == {3'h0, $past(filterCfg_q)};
  endproperty
  a_filterRead: assert property (p_filterRead) else $error("Filter read wrong.");

  property p_matchRead;
    @(posedge clk) disable iff (!reset_n)
    (regRead && regAddr == OFF_MATCH) |=> regRdata == {2'h0, $past(matchVal_q)};
  endproperty
  a_matchRead: assert property (p_matchRead) else $error("Match read wrong.");

  property p_modeHold;
    @(posedge clk) disable iff (!reset_n)
    (!wrMode && !pdRise) |=> $stable(mode_q);
  endproperty
  a_modeHold: assert property (p_modeHold) else $error("Mode changed alone.");

  property p_pdTrack;
    @(posedge clk) disable iff (!reset_n)
    1'b1 |=> pdSeen_q == $past(powerdownPin_n);
  endproperty
  a_pdTrack: assert property (p_pdTrack) else $error("Power-down edge tracker wrong.");

endmodule // legacy_mode_ctrl

// File: hw/legacy_mode_pkg.sv
// Constants for the legacy parallel-video mode control block.
package legacy_mode_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_MODE   = 8'h03;
  localparam logic [7:0] OFF_FORMAT = 8'h04;
  localparam logic [7:0] OFF_FILTER = 8'h10;
  localparam logic [7:0] OFF_MATCH  = 8'h11;
  localparam logic [7:0] OFF_STATUS = 8'h52;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_DONE_BIT = 3;
  localparam int STRAP_OVERRIDE_BIT   = 4;
  localparam int FMT_RAW10_BIT = 2;
  localparam int FMT_RAW12_BIT = 1;
  localparam int FMT_BLOCK_BIT = 0;
  localparam int FLT_ANY_BIT   = 4;
  localparam int FLT_MATCH_BIT = 3;
  localparam int FLT_YUV_BIT   = 2;
  localparam int FLT_FVINV_BIT = 1;
  localparam int FLT_LVINV_BIT = 0;
  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_CSI_SYNC  = 3'h0;
  localparam logic [2:0] MODE_RESERVED  = 3'h1;
  localparam logic [2:0] MODE_CSI_ASYNC = 3'h2;
  localparam logic [2:0] MODE_LEGACY    = 3'h5;
  localparam logic [7:0] RST_REG        = 8'h00;
  localparam logic [5:0] DT_YUV420_10   = 6'h19;
  localparam logic [5:0] DT_YUV420_10CS = 6'h1d;
  localparam logic [5:0] DT_YUV422_10   = 6'h1f;
  localparam logic [5:0] DT_RAW10       = 6'h2b;
  localparam logic [5:0] DT_RAW12       = 6'h2c;
endpackage

// File: tb/deser_model.sv
// Far-end deserializer model that drives the back-channel format load.
`timescale 1ns/1ns
module deser_model
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Bench control
  input  wire logic lockOn,
  input  wire logic sendReq,
  input  wire logic fmt10,
  input  wire logic fmt12,
  // Back channel
  output logic      rxLock,
  output logic      bcLoad,
  output logic      bcRaw10,
  output logic      bcRaw12
);
  assign rxLock = lockOn;
  // The format bits mean something only beside the load strobe.
  // In between they toggle, so a design that samples them unqualified goes wrong.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bcLoad  <= 1'b0;
      bcRaw10 <= 1'b0;
      bcRaw12 <= 1'b0;
    end
    else if (sendReq)
    begin
      bcLoad  <= 1'b1;
      bcRaw10 <= fmt10;
      bcRaw12 <= fmt12;
    end
    else
    begin
      bcLoad  <= 1'b0;
      bcRaw10 <= ~bcRaw10;
      bcRaw12 <= ~bcRaw12;
    end
  end
endmodule // deser_model

// File: tb/tb_top.sv
// Self-checking bench for the legacy mode control block.
`timescale 1ns/1ns
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin errorCnt++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  import legacy_mode_pkg::*;
  typedef struct {logic [7:0] fmt; logic [7:0] flt; logic [5:0] dt; logic pass;} row_s;
  logic clk = 0, reset_n = 0, powerdownPin_n = 1, regWrite = 0, regRead = 0;
  logic [2:0] modeStrap = 3'h5;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, v;
  logic rxLock, bcLoad, bcRaw10, bcRaw12, lockOn = 0, sendReq = 0, fmt10 = 0, fmt12 = 0;
  logic pktValid = 0, frameValidIn = 0, lineValidIn = 0;
  logic [5:0] pktType = 6'h00;
  logic pktPass, frameValidOut, lineValidOut, legacyMode;
  logic [2:0] modeActive;
  int errorCnt = 0, numChecks = 0;
  row_s rows[9] = '{'{8'h04, 8'h00, 6'h2b, 1}, '{8'h04, 8'h00, 6'h2c, 0},
    '{8'h02, 8'h00, 6'h2c, 1}, '{8'h00, 8'h10, 6'h12, 1}, '{8'h00, 8'h10, 6'h0a, 0},
    '{8'h00, 8'h08, 6'h2d, 1}, '{8'h04, 8'h04, 6'h1d, 1}, '{8'h02, 8'h04, 6'h19, 0},
    '{8'h04, 8'h04, 6'h1f, 1}};
  always #2 clk = ~clk;
  legacy_mode_ctrl i_legacy_mode_ctrl (.clk(clk), .reset_n(reset_n),
    .powerdownPin_n(powerdownPin_n), .modeStrap(modeStrap), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .rxLock(rxLock), .bcLoad(bcLoad), .bcRaw10(bcRaw10), .bcRaw12(bcRaw12),
    .pktValid(pktValid), .pktType(pktType), .frameValidIn(frameValidIn),
    .lineValidIn(lineValidIn), .pktPass(pktPass), .frameValidOut(frameValidOut),
    .lineValidOut(lineValidOut), .modeActive(modeActive), .legacyMode(legacyMode));
  deser_model i_deser_model (.clk(clk), .reset_n(reset_n), .lockOn(lockOn),
    .sendReq(sendReq), .fmt10(fmt10), .fmt12(fmt12), .rxLock(rxLock), .bcLoad(bcLoad),
    .bcRaw10(bcRaw10), .bcRaw12(bcRaw12));
  // ----------------------------------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic pkt(input logic [5:0] t, input logic e);
    @(posedge clk);
    pktValid <= 1'b1;
    pktType  <= t;
    @(posedge clk);
    pktValid <= 1'b0;
    #1 `CHK(pktPass, e)
  endtask
  task automatic bcSend(input logic a, input logic b);
    @(posedge clk);
    fmt10   <= a;
    fmt12   <= b;
    sendReq <= 1'b1;
    @(posedge clk);
    sendReq <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic conclude;
    $display("checks=%0d errors=%0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rd(8'h03, v);
    `CHK(v, 8'h0d)
    `CHK({legacyMode, modeActive}, {1'b1, MODE_LEGACY})
    wr(8'h03, 8'h02);
    rd(8'h03, v);
    `CHK(v, 8'h0d)
    wr(8'h03, 8'h10);
    wr(8'h03, 8'h12);
    rd(8'h03, v);
    `CHK(v, 8'h1a)
    `CHK({legacyMode, modeActive}, {1'b0, MODE_CSI_ASYNC})
    wr(8'h03, 8'h15);
    wr(8'h05, 8'h10);
    wr(8'h11, 8'h2d);
    foreach (rows[i])
    begin
      wr(OFF_FORMAT, rows[i].fmt);
      wr(OFF_FILTER, rows[i].flt);
      pkt(rows[i].dt, rows[i].pass);
    end
    wr(8'h10, 8'h08);
    wr(8'h11, 8'h2b);
    rd(8'h11, v);
    `CHK(v, 8'h2d)
    wr(8'h10, 8'h00);
    wr(8'h11, 8'h0d);
    wr(8'h10, 8'h08);
    pkt(6'h0d, 1'b0);
    wr(8'h10, 8'h02);
    frameValidIn <= 1'b1;
    lineValidIn  <= 1'b1;
    repeat (3) @(posedge clk);
    #1 `CHK({frameValidOut, lineValidOut}, 2'b01)
    wr(8'h10, 8'h01);
    repeat (2) @(posedge clk);
    #1 `CHK({frameValidOut, lineValidOut}, 2'b10)
    lockOn <= 1'b1;
    wr(8'h04, 8'h00);
    bcSend(1'b1, 1'b0);
    rd(8'h04, v);
    `CHK(v, 8'h04)
    bcSend(1'b0, 1'b1);
    rd(8'h04, v);
    `CHK(v, 8'h02)
    wr(8'h04, 8'h05);
    bcSend(1'b0, 1'b1);
    rd(8'h04, v);
    `CHK(v, 8'h05)
    rd(OFF_STATUS, v);
    `CHK(v, 8'h00)
    rd(8'h7f, v);
    `CHK(v, 8'h00)
    // Clear the override first, so the strap and not the register sets the mode.
    wr(8'h03, 8'h05);
    modeStrap      <= MODE_CSI_ASYNC;
    powerdownPin_n <= 1'b0;
    repeat (3) @(posedge clk);
    powerdownPin_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(8'h03, v);
    `CHK(v, 8'h0a)
    conclude();
  end
  initial
  begin
    #100000;
    errorCnt++;
    conclude();
  end
endmodule // tb_top
